/* include/lkt_pkg.sv */
// Purpose: shared constants and types for the single-wire bus transceiver control
// Assumes: core_clk at 10 MHz
// Notes:   times are kept in their own unit and turned into cycle counts here
package lkt_pkg;

   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned TO_NOM_MS       = 12;
   localparam int unsigned TO_MIN_MS       = 6;
   localparam int unsigned TO_MAX_MS       = 20;
   localparam int unsigned TO_NOM_CYC      = TO_NOM_MS * (CLK_HZ / 1000);
   localparam int unsigned TO_MIN_CYC      = TO_MIN_MS * (CLK_HZ / 1000);
   localparam int unsigned TO_MAX_CYC      = TO_MAX_MS * (CLK_HZ / 1000);
   localparam int unsigned LIN_MAX_BPS     = 20_000;
   localparam int unsigned FLASH_MAX_BPS   = 115_000;
   localparam int unsigned MIN_BPS_WITH_TO = 1600;

   // ----------------------------------------
   // configuration
   // ----------------------------------------
   typedef enum logic [1:0] {
      LKT_MODE_LIN    = 2'h0,
      LKT_MODE_RXONLY = 2'h1,
      LKT_MODE_FLASH  = 2'h3
   } lkt_mode_t;

   localparam lkt_mode_t MODE_RESET = LKT_MODE_LIN;
   localparam logic      TOE_RESET  = 1'b1;

   typedef struct packed {
      lkt_mode_t mode;
      logic      dominant_timeout_enable;
   } lkt_cfg_t;

   typedef struct packed {
      logic bus_overtemperature_flag;
      logic timeout_active;
   } lkt_diag_t;

   // driver state: gray along normal -> blocked -> hot
   typedef enum logic [1:0] {
      LKT_DRV_ON   = 2'h0,
      LKT_DRV_TOUT = 2'h1,
      LKT_DRV_HOT  = 2'h3
   } lkt_drv_t;

endpackage

/* rtl/lkt_ctrl.sv */
// Purpose: control logic of a single-wire bus transceiver (normal, receive-only, flash)
// Assumes: all inputs synchronous to core_clk; bus pin resolved outside from enable
// Notes:   configuration arrives as a load strobe from the serial control links
//          overtemperature and supply level arrive as clean synchronous levels
//          the bus pin is open drain, so only its enable ever moves
//
// Functional notes
// - receive output follows sensed bus level
// - transmit bits become dominant or recessive
// - three modes: normal, receive-only, flash
// - receive-only never drives bus dominant
// - flash mode disables slope and current limit
// - mode from config field, reset default
// - high transmit input never pulls dominant
// - recessive bus always gives high receive
// - resumes by itself after supply return
// - resumes by itself after short removal
// - long dominant transmit disables driver
// - rising transmit edge re-enables transmission
// - timeout enable bit switches timeout off
// - overtemperature: driver off, flag set
// - overtemperature leaves configuration unchanged
// - no wake-up from bus activity
// - K-Line works in normal mode unchanged
// - timeout nominal 12 ms, 6 to 20
`timescale 1ns/1ns
module lkt_ctrl
   import lkt_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYC = TO_NOM_CYC
) (
   input  wire logic      core_clk,
   input  wire logic      resetn,
   // microcontroller side
   input  wire logic      tx_data,
   output logic           rx_data,
   // bus pin, open-drain: drive low only
   input  wire logic      bus_in,
   output logic           bus_out,
   output logic           bus_oe,
   // analog front end controls
   output logic           slope_ctrl_en,
   output logic           current_limit_en,
   input  wire logic      overtemp_in,
   input  wire logic      supply_ok,
   // configuration load from serial control links
   input  wire logic      cfg_valid,
   output logic           cfg_ready,
   input  lkt_cfg_t       cfg_data,
   output lkt_cfg_t       cfg_q,
   // diagnosis
   input  wire logic      diag_clear,
   output lkt_diag_t      diag_q,
   // received-bit buffer stream
   output logic           rxs_valid,
   input  wire logic      rxs_ready,
   output logic           rxs_data,
   output logic           wake_event
);

   // counter wide enough to hold the limit itself
   localparam int          CW         = $clog2(TIMEOUT_CYC + 1);
   // shortened limits are for simulation runs only
   localparam int unsigned SIM_TO_MAX = 4096;

   // ----------------------------------------
   // elaboration checks
   // ----------------------------------------
   if ((TIMEOUT_CYC < TO_MIN_CYC || TIMEOUT_CYC > TO_MAX_CYC)
       && (TIMEOUT_CYC > SIM_TO_MAX || TIMEOUT_CYC == 0)) begin : g_bad_timeout
      $error("lkt_ctrl: TIMEOUT_CYC out of range");
   end

   // ----------------------------------------
   // configuration register
   // ----------------------------------------
   lkt_cfg_t  cfg_r;
   logic      cfg_ready_r;

   // ready rises on the first clock after reset and stays high; loads are taken from then on
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         cfg_ready_r <= 1'b0;
      end else begin
         cfg_ready_r <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         cfg_r.mode                    <= MODE_RESET;
         cfg_r.dominant_timeout_enable <= TOE_RESET;
      end else if (cfg_valid && cfg_ready_r) begin
         // overtemperature has no path here, so settings survive it
         cfg_r <= cfg_data;
      end
   end

   // ----------------------------------------
   // transmit edge detect and dominant counter
   // ----------------------------------------
   logic          tx_prev_r;
   logic [CW-1:0] dom_cnt_r;
   logic [CW-1:0] dom_cnt_nxt;
   logic          tx_rise;
   logic          to_expire;

   // expire on the last counted low cycle so the driver stops right at the limit
   assign tx_rise   = tx_data && !tx_prev_r;
   assign to_expire = cfg_r.dominant_timeout_enable && !tx_data
                      && (dom_cnt_r >= CW'(TIMEOUT_CYC - 1));

   // saturates at the limit, so a long low never wraps back under it
   always_comb begin
      dom_cnt_nxt = dom_cnt_r;
      if (tx_data) begin
         dom_cnt_nxt = '0;
      end else if (dom_cnt_r != CW'(TIMEOUT_CYC)) begin
         dom_cnt_nxt = dom_cnt_r + CW'(1);
      end
   end

   // resets high like the idle line, so no false edge follows reset
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         tx_prev_r <= 1'b1;
      end else begin
         tx_prev_r <= tx_data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         dom_cnt_r <= '0;
      end else begin
         dom_cnt_r <= dom_cnt_nxt;
      end
   end

   // ----------------------------------------
   // driver state
   // ----------------------------------------
   lkt_drv_t drv_r;
   logic     drv_on;
   logic     drv_tout;

   assign drv_on   = (drv_r == LKT_DRV_ON);
   assign drv_tout = (drv_r == LKT_DRV_TOUT);

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         drv_r <= LKT_DRV_ON;
      end else begin
         // overtemperature outranks the timeout in both working states
         case (drv_r)
            LKT_DRV_ON: begin
               if (overtemp_in) begin
                  drv_r <= LKT_DRV_HOT;
               end else if (to_expire) begin
                  drv_r <= LKT_DRV_TOUT;
               end
            end
            LKT_DRV_TOUT: begin
               if (overtemp_in) begin
                  drv_r <= LKT_DRV_HOT;
               // clearing the enable frees the line here, as a rising transmit edge does
               end else if (tx_rise || !cfg_r.dominant_timeout_enable) begin
                  drv_r <= LKT_DRV_ON;
               end
            end
            LKT_DRV_HOT: begin
               // cooled down: back without bus action
               if (!overtemp_in) begin
                  drv_r <= LKT_DRV_ON;
               end
            end
            default: begin
               // illegal code: fall back to a working driver
               drv_r <= LKT_DRV_ON;
            end
         endcase
      end
   end

   // ----------------------------------------
   // bus driver and front end
   // ----------------------------------------
   logic drive_dom;
   logic mode_rxonly;
   logic mode_flash;

   assign mode_rxonly = (cfg_r.mode == LKT_MODE_RXONLY);
   assign mode_flash  = (cfg_r.mode == LKT_MODE_FLASH);

   // supply loss only gates the driver; no state is held, so recovery is automatic
   // heat gates it at once too, not only a cycle later through the state
   assign drive_dom = !tx_data
                      && drv_on
                      && !mode_rxonly
                      && !overtemp_in
                      && supply_ok;

   // open drain: the data bit never leaves low
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         bus_out <= 1'b0;
      end else begin
         bus_out <= 1'b0;
      end
   end

   // reset leaves the driver off
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         bus_oe <= 1'b0;
      end else begin
         bus_oe <= drive_dom;
      end
   end

   // shaping is dropped only in flash mode, where edges must be fast
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         slope_ctrl_en    <= 1'b1;
         current_limit_en <= 1'b1;
      end else begin
         slope_ctrl_en    <= !mode_flash;
         current_limit_en <= !mode_flash;
      end
   end

   // ----------------------------------------
   // receive path
   // ----------------------------------------
   // one stage; off the supply range a recessive line still reads high
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rx_data <= 1'b1;
      end else begin
         rx_data <= bus_in;
      end
   end

   // ----------------------------------------
   // diagnosis: set wins over clear
   // ----------------------------------------
   lkt_diag_t diag_r;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         diag_r <= '0;
      end else begin
         diag_r.bus_overtemperature_flag <= overtemp_in
            || (diag_r.bus_overtemperature_flag && !diag_clear);
         diag_r.timeout_active <= drv_tout;
      end
   end

   // ----------------------------------------
   // two-entry buffer of received bus edges
   // ----------------------------------------
   // write side offers each change of level; a change met by a full buffer
   // stays offered, so the next word carries the level that the bus has then
   logic in_valid;
   logic in_ready;
   logic in_bit;
   logic push;
   logic pop;
   logic rx_prev_r;
   logic head_v_r;
   logic head_d_r;
   logic tail_v_r;
   logic tail_d_r;

   assign in_bit   = bus_in;
   assign in_valid = (bus_in != rx_prev_r);
   // no pass-through on a full buffer: keeps the reader's ready off this path
   assign in_ready = !tail_v_r;
   assign push     = in_valid && in_ready;
   assign pop      = head_v_r && rxs_ready;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rx_prev_r <= 1'b1;
      end else if (push) begin
         rx_prev_r <= in_bit;
      end
   end

   // head slot drives the stream and holds while the reader stalls;
   // on a pop it takes the tail, or the new word when the tail is empty
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         head_v_r <= 1'b0;
         head_d_r <= 1'b1;
      end else if (pop) begin
         head_v_r <= tail_v_r || push;
         head_d_r <= tail_v_r ? tail_d_r : in_bit;
      end else if (!head_v_r && push) begin
         head_v_r <= 1'b1;
         head_d_r <= in_bit;
      end
   end

   // tail slot fills only behind a valid head
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         tail_v_r <= 1'b0;
         tail_d_r <= 1'b1;
      end else if (pop) begin
         tail_v_r <= 1'b0;
      end else if (head_v_r && push) begin
         tail_v_r <= 1'b1;
         tail_d_r <= in_bit;
      end
   end

   assign rxs_valid = head_v_r;
   assign rxs_data  = head_d_r;

   // ----------------------------------------
   // wake-up
   // ----------------------------------------
   // no wake-up source exists on this pin; held low by a register all the same
   logic wake_r;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         wake_r <= 1'b0;
      end else begin
         wake_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // all of these come straight from registers
   assign cfg_q      = cfg_r;
   assign cfg_ready  = cfg_ready_r;
   assign diag_q     = diag_r;
   assign wake_event = wake_r;

endmodule

/* test/lin_kline_transceiver_control_bench.sv */
// Purpose: self-checking bench of the transceiver control
// Assumes: short timeout parameter for run time
// Notes:   stream ready stalls at random
`timescale 1ns/1ns
module lin_kline_transceiver_control_bench;
   import lkt_pkg::*;
   localparam int unsigned TCYC = 50;
   logic core_clk = 1'b0, resetn = 1'b0, tx_data = 1'b1, other_dom = 1'b0;
   logic overtemp_in = 1'b0, supply_ok = 1'b1, cfg_valid = 1'b0, diag_clear = 1'b0;
   logic rxs_ready = 1'b1, bus_in, rx_data, bus_oe, bus_out, slope_ctrl_en;
   logic current_limit_en, cfg_ready, rxs_valid, rxs_data, wake_event;
   lkt_cfg_t  cfg_data = '0, cfg_q, saved;
   lkt_diag_t diag_q;
   int        mismatches = 0, compares = 0;
   lkt_mode_t ml[3] = '{LKT_MODE_LIN, LKT_MODE_RXONLY, LKT_MODE_FLASH};
   always #50 core_clk = ~core_clk;
   lkt_ctrl #(.TIMEOUT_CYC(TCYC)) u_dut (.core_clk, .resetn, .tx_data, .rx_data,
      .bus_in, .bus_out, .bus_oe, .slope_ctrl_en, .current_limit_en, .overtemp_in,
      .supply_ok, .cfg_valid, .cfg_ready, .cfg_data, .cfg_q, .diag_clear, .diag_q,
      .rxs_valid, .rxs_ready, .rxs_data, .wake_event);
   lkt_bus_model u_bus (.bus_oe, .bus_out, .other_dom, .bus_in);
   // ----
   // helpers
   // ----
   task cyc(input int n);
      repeat (n) begin
         @(posedge core_clk);
         #1 rxs_ready = 1'($urandom);
      end
   endtask
   task chk(input logic [3:0] s, input logic [3:0] e);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task ld(input lkt_mode_t m, input logic t);
      cfg_data = '{m, t};
      cfg_valid = 1'b1;
      cyc(1);
      cfg_valid = 1'b0;
      cyc(2);
   endtask
   function logic exp_oe(input lkt_mode_t m, input logic tx);
      return !tx && m != LKT_MODE_RXONLY;
   endfunction
   task tally_and_finish;
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      int i;
      void'($urandom(42));
      repeat (6) @(posedge core_clk);
      #1 resetn = 1'b1;
      chk(rx_data, 1'b1);
      chk(cfg_q, {MODE_RESET, TOE_RESET});
      for (i = 0; i < 10 && cfg_ready !== 1'b1; i++) cyc(1);
      if (cfg_ready !== 1'b1) begin
         mismatches++;
         tally_and_finish;
      end
      for (i = 0; i < 20; i++) begin
         tx_data = (i % 4 == 3) ? 1'b1 : 1'($urandom);
         cyc(3);
         chk(rx_data, tx_data);
      end
      tx_data = 1'b1;
      cyc(3);
      for (i = 0; i < 30 && rxs_valid !== 1'b0; i++) cyc(1);
      chk(rxs_valid, 1'b0);
      tx_data = 1'b0;
      cyc(2);
      chk(rxs_valid, 1'b1);
      chk(rxs_data, 1'b0);
      $display("test stream done");
      foreach (ml[j]) begin
         ld(ml[j], 1'b1);
         tx_data = 1'b0;
         cyc(3);
         chk(bus_oe, exp_oe(ml[j], 1'b0));
         chk(slope_ctrl_en, ml[j] != LKT_MODE_FLASH);
         chk(current_limit_en, ml[j] != LKT_MODE_FLASH);
         tx_data = 1'b1;
         other_dom = 1'b1;
         cyc(3);
         chk(rx_data, 1'b0);
         other_dom = 1'b0;
         cyc(2);
      end
      $display("test modes done");
      ld(LKT_MODE_LIN, 1'b1);
      tx_data = 1'b0;
      cyc(TCYC + 10);
      chk(bus_oe, 1'b0);
      chk(diag_q.timeout_active, 1'b1);
      tx_data = 1'b1;
      cyc(2);
      tx_data = 1'b0;
      cyc(TCYC - 10);
      chk(bus_oe, 1'b1);
      tx_data = 1'b1;
      ld(LKT_MODE_LIN, 1'b0);
      tx_data = 1'b0;
      cyc(TCYC + 10);
      chk(bus_oe, 1'b1);
      $display("test timeout done");
      saved = cfg_q;
      overtemp_in = 1'b1;
      cyc(2);
      chk(bus_oe, 1'b0);
      chk(diag_q.bus_overtemperature_flag, 1'b1);
      chk(cfg_q, saved);
      overtemp_in = 1'b0;
      diag_clear = 1'b1;
      cyc(1);
      diag_clear = 1'b0;
      cyc(3);
      chk(bus_oe, 1'b1);
      chk(diag_q.bus_overtemperature_flag, 1'b0);
      supply_ok = 1'b0;
      cyc(2);
      chk(bus_oe, 1'b0);
      chk(rx_data, 1'b1);
      supply_ok = 1'b1;
      cyc(3);
      chk(bus_oe, 1'b1);
      tx_data = 1'b1;
      cyc(3);
      $display("test faults done");
      tally_and_finish;
   end
endmodule

/* test/lkt_bus_model.sv */
// Purpose: far side of the bus pin: pull-up plus other nodes
// Assumes: open-drain pin, recessive is high
// Notes:   other_dom stands in for any other node pulling low
`timescale 1ns/1ns
module lkt_bus_model (
   input wire logic bus_oe,
   input wire logic bus_out,
   input wire logic other_dom,
   output logic     bus_in
);
   // wired-and with pull-up, so a released line reads high
   assign bus_in = !((bus_oe && !bus_out) || other_dom);
endmodule

/* test/lkt_chk.sv */
// Purpose: port-level checks of the transceiver control
// Assumes: single clock, sync active-low reset
// Notes:   counter window has one cycle of slack
`timescale 1ns/1ns
module lkt_chk
   import lkt_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYC = TO_NOM_CYC
) (
   input logic      core_clk,
   input logic      resetn,
   input logic      tx_data,
   input logic      rx_data,
   input logic      bus_in,
   input logic      bus_oe,
   input logic      slope_ctrl_en,
   input logic      current_limit_en,
   input logic      overtemp_in,
   input logic      supply_ok,
   input logic      cfg_valid,
   input logic      cfg_ready,
   input lkt_cfg_t  cfg_data,
   input lkt_cfg_t  cfg_q,
   input lkt_diag_t diag_q,
   input logic      rxs_valid,
   input logic      rxs_ready,
   input logic      rxs_data,
   input logic      wake_event
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // ----
   // consecutive dominant cycles with timeout on
   // ----
   localparam int LW = $clog2(TIMEOUT_CYC + 3);
   logic [LW-1:0] low_cnt;
   logic          ok;
   assign ok = supply_ok && !overtemp_in && cfg_q.mode == LKT_MODE_LIN && !cfg_valid;
   always_ff @(posedge core_clk) begin
      if (!resetn || tx_data || !cfg_q.dominant_timeout_enable) begin
         low_cnt <= '0;
      end else if (low_cnt != '1) begin
         low_cnt <= low_cnt + 1'b1;
      end
   end
   property p_rx; $past(resetn) |-> rx_data == $past(bus_in); endproperty
   a_rx: assert property (p_rx) else $error("rx not bus copy");
   property p_tx_hi; tx_data |=> !bus_oe; endproperty
   a_tx_hi: assert property (p_tx_hi) else $error("dominant on high tx");
   property p_drive; (tx_data && ok)[*2] ##1 (!tx_data && ok) |=> bus_oe; endproperty
   a_drive: assert property (p_drive) else $error("no dominant on low tx");
   property p_rxo; cfg_q.mode == LKT_MODE_RXONLY |=> !bus_oe; endproperty
   a_rxo: assert property (p_rxo) else $error("drive in rx only");
   property p_flash; cfg_q.mode == LKT_MODE_FLASH |=> !slope_ctrl_en && !current_limit_en;
   endproperty
   a_flash: assert property (p_flash) else $error("shaping on in flash");
   property p_cfg; cfg_valid && cfg_ready |=> cfg_q == $past(cfg_data); endproperty
   a_cfg: assert property (p_cfg) else $error("config not loaded");
   property p_keep; !cfg_valid |=> $stable(cfg_q); endproperty
   a_keep: assert property (p_keep) else $error("config changed");
   property p_ot; overtemp_in |=> !bus_oe && diag_q.bus_overtemperature_flag; endproperty
   a_ot: assert property (p_ot) else $error("hot driver on");
   property p_sup; !supply_ok && bus_in |=> rx_data; endproperty
   a_sup: assert property (p_sup) else $error("rx low on recessive");
   property p_to; low_cnt > TIMEOUT_CYC + 1 |-> !bus_oe; endproperty
   a_to: assert property (p_to) else $error("timeout missed");
   property p_wake; !wake_event; endproperty
   a_wake: assert property (p_wake) else $error("wake event seen");
   property p_hold; rxs_valid && !rxs_ready |=> rxs_valid && $stable(rxs_data); endproperty
   a_hold: assert property (p_hold) else $error("stream word lost");
   c_to: cover property (low_cnt == TIMEOUT_CYC + 2);
   c_ot: cover property (overtemp_in);
   c_fl: cover property (cfg_q.mode == LKT_MODE_FLASH);
   c_st: cover property (rxs_valid && !rxs_ready);
endmodule
bind lkt_ctrl lkt_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (.core_clk, .resetn, .tx_data,
   .rx_data, .bus_in, .bus_oe, .slope_ctrl_en, .current_limit_en, .overtemp_in,
   .supply_ok, .cfg_valid, .cfg_ready, .cfg_data, .cfg_q, .diag_q, .rxs_valid,
   .rxs_ready, .rxs_data, .wake_event);
